// ==== core/hcrb_params.svh ====
`ifndef HCRB_PARAMS_SVH
`define HCRB_PARAMS_SVH
// i2c target address
`define HCRB_I2C_ADDR 7'h41
// register offsets
`define HCRB_OFS_REV 8'h00
`define HCRB_OFS_S1A 8'h01
`define HCRB_OFS_S1B 8'h02
`define HCRB_OFS_S2A 8'h03
`define HCRB_OFS_S2B 8'h04
`define HCRB_OFS_CTRL 8'h14
// reset values
`define HCRB_RST_REG_A 8'h01
`define HCRB_RST_REG_B 8'h00
`define HCRB_RST_CTRL 8'h00
// revision numbers, arbitrary values
`define HCRB_REV_MAJOR 4'h1
`define HCRB_REV_MINOR 4'h0
// field positions
`define HCRB_CTRL_UPD 0
`define HCRB_CTRL_BUSY 2
`define HCRB_A_MODE 0
`define HCRB_LVL_BIT5 5
// level code limits
`define HCRB_LVL_LOW 8'h0d
`define HCRB_LVL_TOP 8'hc6
// copy duration in clock cycles
`define HCRB_COPY_CYC 4'h8
// read data for unmapped offsets
`define HCRB_RD_NONE 8'h00
`endif

// ==== core/hcrb_pkg.sv ====
package hcrb_pkg;
  // one source's regulation register pair
  typedef struct packed {
    logic [7:0] reg_a;
    logic [7:0] reg_b;
  } hcrb_src_s;
  // decoded regulation settings of one source
  typedef struct packed {
    logic mppt_mode;
    logic [7:0] voltage_level_code;
    logic below_low_source;
    logic [2:0] tracking_ratio_code;
    logic [2:0] sampling_duration_code;
    logic [2:0] tracking_period_code;
  } hcrb_reg_cfg_s;
  // register write strobe with address and data
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
  } hcrb_wr_s;
  typedef enum logic [2:0] {
    HCRB_IDLE, HCRB_ADDR, HCRB_ACK, HCRB_REGA, HCRB_WDAT, HCRB_RDAT, HCRB_RACK
  } hcrb_i2c_e;
endpackage : hcrb_pkg

// ==== core/hcrb_src_decode.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "hcrb_params.svh"
// decodes one source's applied register pair into regulation settings
module hcrb_src_decode
  import hcrb_pkg::*;
(
  // applied register pair
  input wire hcrb_pkg::hcrb_src_s i_src,
  // decoded settings
  output hcrb_pkg::hcrb_reg_cfg_s o_cfg
);
  logic [7:0] lvl;
  always_comb
  begin
    o_cfg.mppt_mode = i_src.reg_a[`HCRB_A_MODE];
    // level code assembly; bit 5 of reg_b never enters it
    lvl = {i_src.reg_b[4:3], i_src.reg_b[2:0], i_src.reg_a[3:1]};
    // top codes saturate at the highest voltage code
    if (lvl >= `HCRB_LVL_TOP)
      lvl = `HCRB_LVL_TOP;
    o_cfg.voltage_level_code = lvl;
    o_cfg.below_low_source = ~o_cfg.mppt_mode &
      (lvl < `HCRB_LVL_LOW);
    o_cfg.tracking_ratio_code = i_src.reg_a[3:1];
    o_cfg.sampling_duration_code = i_src.reg_b[2:0];
    o_cfg.tracking_period_code = i_src.reg_b[5:3];
  end
endmodule : hcrb_src_decode
`default_nettype wire

// ==== core/hcrb_i2c_target.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "hcrb_params.svh"
// i2c target: byte-wide register access with auto increment
module hcrb_i2c_target
  import hcrb_pkg::*;
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_srst,
  // i2c pins, sampled synchronously
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_oe,
  // register side
  output hcrb_pkg::hcrb_wr_s o_wr,
  output logic [7:0] o_raddr,
  input wire logic [7:0] i_rdata
);
  hcrb_i2c_e state_ff;
  logic scl_d_ff, sda_d_ff, rw_ff;
  // set by a write address: the next byte is the register pointer
  logic ptr_next_ff;
  logic [7:0] sh_ff, ptr_ff;
  logic [3:0] cnt_ff;
  logic scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = i_scl & ~scl_d_ff;
  assign scl_fall = ~i_scl & scl_d_ff;
  assign start_c = i_scl & scl_d_ff & sda_d_ff & ~i_sda;
  assign stop_c = i_scl & scl_d_ff & ~sda_d_ff & i_sda;
  assign o_raddr = ptr_ff;
  // edge history
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end
    else
    begin
      scl_d_ff <= i_scl;
      sda_d_ff <= i_sda;
    end
  end
  // protocol engine; sda changes only after scl falls
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      state_ff <= HCRB_IDLE;
      sh_ff <= 8'h00;
      ptr_ff <= 8'h00;
      cnt_ff <= 4'h0;
      rw_ff <= 1'b0;
      ptr_next_ff <= 1'b0;
      o_sda_oe <= 1'b0;
      o_wr <= '0;
    end
    else
    begin
      o_wr.wr <= 1'b0;
      if (start_c)
      begin
        state_ff <= HCRB_ADDR;
        cnt_ff <= 4'h0;
        o_sda_oe <= 1'b0;
      end
      else if (stop_c)
      begin
        state_ff <= HCRB_IDLE;
        o_sda_oe <= 1'b0;
      end
      else
      begin
        case (state_ff)
          HCRB_IDLE: ;
          HCRB_ADDR, HCRB_REGA, HCRB_WDAT:
          begin
            if (scl_rise)
            begin
              sh_ff <= {sh_ff[6:0], i_sda};
              cnt_ff <= cnt_ff + 4'h1;
            end
            else if (scl_fall && cnt_ff == 4'h8)
            begin
              cnt_ff <= 4'h0;
              if (state_ff == HCRB_ADDR)
              begin
                // answer only our own address
                if (sh_ff[7:1] == `HCRB_I2C_ADDR)
                begin
                  rw_ff <= sh_ff[0];
                  ptr_next_ff <= ~sh_ff[0];
                  o_sda_oe <= 1'b1;
                  state_ff <= HCRB_ACK;
                end
                else
                  state_ff <= HCRB_IDLE;
              end
              else
              begin
                o_sda_oe <= 1'b1;
                if (state_ff == HCRB_REGA)
                  ptr_ff <= sh_ff;
                else
                begin
                  o_wr <= '{wr: 1'b1, addr: ptr_ff, data: sh_ff};
                  ptr_ff <= ptr_ff + 8'h01;
                end
                state_ff <= HCRB_ACK;
              end
            end
          end
          HCRB_ACK:
          begin
            if (scl_fall)
            begin
              if (rw_ff)
              begin
                sh_ff <= i_rdata;
                o_sda_oe <= ~i_rdata[7];
                cnt_ff <= 4'h1;
                state_ff <= HCRB_RDAT;
              end
              else
              begin
                o_sda_oe <= 1'b0;
                // a flag, not the shifted byte: data equal to the
                // address byte must not be taken for a new pointer
                state_ff <= ptr_next_ff ? HCRB_REGA : HCRB_WDAT;
                ptr_next_ff <= 1'b0;
              end
            end
          end
          HCRB_RDAT:
          begin
            if (scl_fall)
            begin
              if (cnt_ff == 4'h8)
              begin
                o_sda_oe <= 1'b0;
                state_ff <= HCRB_RACK;
              end
              else
              begin
                o_sda_oe <= ~sh_ff[6];
                sh_ff <= {sh_ff[6:0], 1'b0};
                cnt_ff <= cnt_ff + 4'h1;
              end
            end
          end
          HCRB_RACK:
          begin
            // ack advances to the next register, nack ends the read
            if (scl_rise)
            begin
              if (!i_sda)
              begin
                ptr_ff <= ptr_ff + 8'h01;
                state_ff <= HCRB_ACK;
              end
              else
                state_ff <= HCRB_IDLE;
            end
          end
          default: state_ff <= HCRB_IDLE;
        endcase
      end
    end
  end
endmodule : hcrb_i2c_target
`default_nettype wire

// ==== core/hcrb_config_bank.sv ====
// Overview of operation
// - control bit 2 shows copy in progress
// - update bit picks bus or strap configuration
// - update bit reads back configuration source
// - writes apply only on next update write
// - read-only revision register at offset zero
// - mode bit picks constant voltage or tracking
// - three fields form 8-bit level code
// - constant voltage ignores second register bit 5
// - constant voltage codes below 0x0d mean low source
// - codes 0xc6 up saturate at top
// - 3-bit tracking ratio code decoding
// - 3-bit sampling duration code decoding
// - 3-bit tracking period code decoding
// - sampling low field, period high field
// - target address 0x41
// - ack advances read, nack ends it
`timescale 1ns/1ps
`default_nettype none
`include "hcrb_params.svh"
module hcrb_config_bank
  import hcrb_pkg::*;
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_srst,
  // i2c pins
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_oe,
  // strap pin configuration per source
  input wire hcrb_pkg::hcrb_src_s i_strap_src1,
  input wire hcrb_pkg::hcrb_src_s i_strap_src2,
  // applied configuration
  output hcrb_pkg::hcrb_reg_cfg_s o_cfg_src1,
  output hcrb_pkg::hcrb_reg_cfg_s o_cfg_src2,
  output logic o_bus_config,
  output logic o_copy_in_progress_flag
);
  import hcrb_pkg::*;

  // ************************************************************
  // bus access
  // ************************************************************
  hcrb_wr_s wr;
  logic [7:0] raddr, rdata;
  logic sda_oe;
  hcrb_i2c_target u_i2c (
    .i_sys_clk(i_sys_clk),
    .i_srst(i_srst),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .o_sda_oe(sda_oe),
    .o_wr(wr),
    .o_raddr(raddr),
    .i_rdata(rdata)
  );
  // already registered inside the target
  assign o_sda_oe = sda_oe;

  // ************************************************************
  // bus-side registers
  // ************************************************************
  hcrb_src_s bus_src1_ff, bus_src2_ff;
  logic upd_ff, busy_ff;
  logic [3:0] copy_cnt_ff;
  localparam logic [7:0] ctrl_rst = `HCRB_RST_CTRL;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = wr.wr && (a == o);
  endfunction : hit

  // register writes; reserved bits stay zero
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      bus_src1_ff <= '{reg_a: `HCRB_RST_REG_A, reg_b: `HCRB_RST_REG_B};
      bus_src2_ff <= '{reg_a: `HCRB_RST_REG_A, reg_b: `HCRB_RST_REG_B};
    end
    else
    begin
      // separate pairs per source
      if (hit(wr.addr, `HCRB_OFS_S1A))
        bus_src1_ff.reg_a <= {4'h0, wr.data[3:0]};
      if (hit(wr.addr, `HCRB_OFS_S1B))
        bus_src1_ff.reg_b <= {2'h0, wr.data[5:0]};
      if (hit(wr.addr, `HCRB_OFS_S2A))
        bus_src2_ff.reg_a <= {4'h0, wr.data[3:0]};
      if (hit(wr.addr, `HCRB_OFS_S2B))
        bus_src2_ff.reg_b <= {2'h0, wr.data[5:0]};
    end
  end

  // update bit and copy sequencer; busy lasts a fixed copy time
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      upd_ff <= ctrl_rst[`HCRB_CTRL_UPD];
      busy_ff <= 1'b0;
      copy_cnt_ff <= 4'h0;
    end
    else if (hit(wr.addr, `HCRB_OFS_CTRL))
    begin
      upd_ff <= wr.data[`HCRB_CTRL_UPD];
      busy_ff <= 1'b1;
      copy_cnt_ff <= `HCRB_COPY_CYC;
    end
    else if (busy_ff)
    begin
      copy_cnt_ff <= copy_cnt_ff - 4'h1;
      if (copy_cnt_ff == 4'h1)
        busy_ff <= 1'b0;
    end
  end

  // ************************************************************
  // applied (system) registers
  // ************************************************************
  hcrb_src_s sys_src1_ff, sys_src2_ff;
  // snapshot at the end of copy; later bus writes stay invisible
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      sys_src1_ff <= '{reg_a: `HCRB_RST_REG_A, reg_b: `HCRB_RST_REG_B};
      sys_src2_ff <= '{reg_a: `HCRB_RST_REG_A, reg_b: `HCRB_RST_REG_B};
    end
    else if (busy_ff && copy_cnt_ff == 4'h1)
    begin
      sys_src1_ff <= upd_ff ? bus_src1_ff : i_strap_src1;
      sys_src2_ff <= upd_ff ? bus_src2_ff : i_strap_src2;
    end
  end

  // ************************************************************
  // read mux
  // ************************************************************
  always_comb
  begin
    case (raddr)
      `HCRB_OFS_REV: rdata = {`HCRB_REV_MAJOR, `HCRB_REV_MINOR};
      `HCRB_OFS_S1A: rdata = bus_src1_ff.reg_a;
      `HCRB_OFS_S1B: rdata = bus_src1_ff.reg_b;
      `HCRB_OFS_S2A: rdata = bus_src2_ff.reg_a;
      `HCRB_OFS_S2B: rdata = bus_src2_ff.reg_b;
      `HCRB_OFS_CTRL: rdata = {5'h00, busy_ff, 1'b0, upd_ff};
      default: rdata = `HCRB_RD_NONE;
    endcase
  end

  // ************************************************************
  // decode and outputs
  // ************************************************************
  hcrb_reg_cfg_s dec1, dec2;
  hcrb_src_decode u_dec1 (.i_src(sys_src1_ff), .o_cfg(dec1));
  hcrb_src_decode u_dec2 (.i_src(sys_src2_ff), .o_cfg(dec2));
  // decoded settings follow the applied registers, also in reset, so
  // the reset tracking mode shows and nothing jumps at release
  always_ff @(posedge i_sys_clk)
  begin
    o_cfg_src1 <= dec1;
    o_cfg_src2 <= dec2;
  end
  // registered status outputs; one cycle behind the sequencer
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      o_bus_config <= 1'b0;
      o_copy_in_progress_flag <= 1'b0;
    end
    else
    begin
      o_bus_config <= upd_ff;
      o_copy_in_progress_flag <= busy_ff;
    end
  end
endmodule : hcrb_config_bank
`default_nettype wire

// ==== test/hcrb_config_bank_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module hcrb_config_bank_monitor
  import hcrb_pkg::*;
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_srst,
  // watched pins
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda_oe,
  input wire hcrb_pkg::hcrb_src_s i_strap_src1,
  input wire hcrb_pkg::hcrb_src_s i_strap_src2,
  input wire hcrb_pkg::hcrb_reg_cfg_s o_cfg_src1,
  input wire hcrb_pkg::hcrb_reg_cfg_s o_cfg_src2,
  input wire logic o_bus_config,
  input wire logic o_copy_in_progress_flag
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  // ****
  // checks
  // ****
  logic [2:0] busy_ff;
  // busy history: decoded settings outputs may only move just after a copy
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
      busy_ff <= 3'h0;
    else
      busy_ff <= {busy_ff[1:0], o_copy_in_progress_flag};
  end
  a_busy_len_exact: assert property ($rose(o_copy_in_progress_flag) |->
    o_copy_in_progress_flag[*8] ##1 !o_copy_in_progress_flag)
    else $error("copy busy length wrong");
  a_second_config_field_after_copy: assert property ($changed(o_cfg_src1) |-> |busy_ff)
    else $error("source one settings moved outside a copy");
  a_third_config_field_after_copy: assert property ($changed(o_cfg_src2) |-> |busy_ff)
    else $error("source two settings moved outside a copy");
  a_mode_after_copy: assert property ($changed(o_bus_config) |->
    $rose(o_copy_in_progress_flag))
    else $error("config source moved outside a copy");
  a_level_clamp_top: assert property (!o_cfg_src1.mppt_mode |->
    o_cfg_src1.voltage_level_code <= 8'hc6)
    else $error("level code above top");
  a_low_flag_one: assert property (!o_cfg_src1.mppt_mode |->
    o_cfg_src1.below_low_source == (o_cfg_src1.voltage_level_code < 8'h0d))
    else $error("source one low flag wrong");
  a_low_flag_two: assert property (!o_cfg_src2.mppt_mode |->
    o_cfg_src2.below_low_source == (o_cfg_src2.voltage_level_code < 8'h0d))
    else $error("source two low flag wrong");
  a_sda_scl_high: assert property (i_scl && $past(i_scl) |->
    $stable(o_sda_oe))
    else $error("sda moved while scl high");
  c_copy: cover property ($rose(o_copy_in_progress_flag));
  c_track: cover property (o_cfg_src2.mppt_mode);
  c_low: cover property (o_cfg_src1.below_low_source);
endmodule : hcrb_config_bank_monitor
bind hcrb_config_bank hcrb_config_bank_monitor u_hcrb_config_bank_monitor (
  .i_sys_clk, .i_srst, .i_scl, .i_sda, .o_sda_oe, .i_strap_src1,
  .i_strap_src2, .o_cfg_src1, .o_cfg_src2, .o_bus_config,
  .o_copy_in_progress_flag);
`default_nettype wire

// ==== test/hcrb_i2c_host.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "hcrb_params.svh"
module hcrb_i2c_host (
  // clock
  input wire logic i_sys_clk,
  // bus
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_oe
);
  // ****
  // bus controller
  // ****
  // idle released, the pull-up holds sda high
  initial
  begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask : tick
  // data set while scl low, sampled at the high phase
  task automatic bit_io(input logic b, output logic r);
    o_sda_oe <= ~b;
    tick(4);
    o_scl <= 1'b1;
    tick(4);
    r = i_sda;
    o_scl <= 1'b0;
    tick(2);
  endtask : bit_io
  task automatic start_c();
    o_sda_oe <= 1'b0;
    tick(2);
    o_scl <= 1'b1;
    tick(4);
    o_sda_oe <= 1'b1;
    tick(4);
    o_scl <= 1'b0;
    tick(2);
  endtask : start_c
  task automatic stop_c();
    o_sda_oe <= 1'b1;
    tick(4);
    o_scl <= 1'b1;
    tick(4);
    o_sda_oe <= 1'b0;
    tick(4);
  endtask : stop_c
  // one byte msb first plus the ack slot
  task automatic xfer(input logic [7:0] d, input logic ai,
                      output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(ai, a);
  endtask : xfer
  task automatic wr(input logic [6:0] dev, input logic [7:0] ptr, input int n,
                    input logic [7:0] d [4], output logic ack);
    logic [7:0] q;
    logic a;
    start_c();
    xfer({dev, 1'b0}, 1'b1, q, ack);
    xfer(ptr, 1'b1, q, a);
    for (int i = 0; i < n; i++)
      xfer(d[i], 1'b1, q, a);
    stop_c();
  endtask : wr
  task automatic rd(input logic [7:0] ptr, input int n,
                    output logic [7:0] q [5]);
    logic [7:0] x;
    logic a;
    start_c();
    xfer({`HCRB_I2C_ADDR, 1'b0}, 1'b1, x, a);
    xfer(ptr, 1'b1, x, a);
    start_c();
    xfer({`HCRB_I2C_ADDR, 1'b1}, 1'b1, x, a);
    for (int i = 0; i < n; i++)
      xfer(8'hff, i == n - 1, q[i], a);
    stop_c();
  endtask : rd
endmodule : hcrb_i2c_host
`default_nettype wire

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "hcrb_params.svh"
module tb_top;
  import hcrb_pkg::*;
  // ****
  // bench
  // ****
  logic i_sys_clk = 1'b0;
  logic i_srst = 1'b1;
  logic scl;
  logic host_oe;
  logic dev_oe;
  logic bus_cfg;
  logic busy;
  logic ack;
  hcrb_src_s strap1 = '0;
  hcrb_src_s strap2 = '0;
  hcrb_reg_cfg_s second_config_field;
  hcrb_reg_cfg_s third_config_field;
  logic [7:0] q [5];
  int err_count = 0;
  int n_compared = 0;
  logic [3:0] busy_run = 4'h0;
  logic [3:0] busy_len = 4'h0;
  // open drain with pull-up
  wire logic sda = ~(host_oe | dev_oe);
  always #5 i_sys_clk = ~i_sys_clk;
  // length of the last busy pulse; too short to catch over the bus
  always @(posedge i_sys_clk)
  begin
    if (busy === 1'b1)
      busy_run <= busy_run + 4'h1;
    else if (busy_run != 4'h0)
    begin
      busy_len <= busy_run;
      busy_run <= 4'h0;
    end
  end
  hcrb_config_bank u_hcrb_config_bank (.i_sys_clk(i_sys_clk),
    .i_srst(i_srst), .i_scl(scl), .i_sda(sda), .o_sda_oe(dev_oe),
    .i_strap_src1(strap1), .i_strap_src2(strap2), .o_cfg_src1(second_config_field),
    .o_cfg_src2(third_config_field), .o_bus_config(bus_cfg),
    .o_copy_in_progress_flag(busy));
  hcrb_i2c_host u_hcrb_i2c_host (.i_sys_clk(i_sys_clk), .i_sda(sda),
    .o_scl(scl), .o_sda_oe(host_oe));
  task automatic chk(input string nm, input logic [11:0] e,
                     input logic [11:0] g);
    n_compared++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  function automatic logic [11:0] cv(input hcrb_reg_cfg_s c);
    return {2'b0, c.mppt_mode, c.voltage_level_code, c.below_low_source};
  endfunction : cv
  function automatic logic [11:0] mp(input hcrb_reg_cfg_s c);
    return {2'b0, c.mppt_mode, c.tracking_ratio_code,
            c.sampling_duration_code, c.tracking_period_code};
  endfunction : mp
  // update write, then poll busy over the bus before trusting it
  task automatic apply(input logic v);
    u_hcrb_i2c_host.wr(`HCRB_I2C_ADDR, `HCRB_OFS_CTRL, 1,
                       '{{7'h0, v}, 8'h0, 8'h0, 8'h0}, ack);
    for (int i = 0; i < 4; i++)
    begin
      u_hcrb_i2c_host.rd(`HCRB_OFS_CTRL, 1, q);
      if (q[0][2] === 1'b0)
        break;
    end
    chk("ctrl", {11'h0, v}, q[0]);
    chk("busy_len", `HCRB_COPY_CYC, busy_len);
    repeat (4) @(posedge i_sys_clk);
  endtask : apply
  // watchdog well past the expected run
  initial
  begin
    repeat (60000) @(posedge i_sys_clk);
    err_count++;
    end_sim();
  end
  initial
  begin
    repeat (8) @(posedge i_sys_clk);
    i_srst <= 1'b0;
    u_hcrb_i2c_host.rd(`HCRB_OFS_REV, 5, q);
    chk("rev", {`HCRB_REV_MAJOR, `HCRB_REV_MINOR}, q[0]);
    chk("s1a", `HCRB_RST_REG_A, q[1]);
    chk("s1b", `HCRB_RST_REG_B, q[2]);
    chk("s2a", `HCRB_RST_REG_A, q[3]);
    chk("s2b", `HCRB_RST_REG_B, q[4]);
    u_hcrb_i2c_host.wr(7'h42, `HCRB_OFS_REV, 1, '{8'hff, 8'h0, 8'h0, 8'h0}, ack);
    chk("nack", 12'h1, ack);
    u_hcrb_i2c_host.wr(`HCRB_I2C_ADDR, `HCRB_OFS_REV, 1,
                       '{8'hff, 8'h0, 8'h0, 8'h0}, ack);
    u_hcrb_i2c_host.rd(`HCRB_OFS_REV, 1, q);
    chk("rev_ro", {`HCRB_REV_MAJOR, `HCRB_REV_MINOR}, q[0]);
    $display("test reset done");
    // level 0x6d with bit 5 set, tracking on source two
    u_hcrb_i2c_host.wr(`HCRB_I2C_ADDR, `HCRB_OFS_S1A, 4,
                       '{8'h0a, 8'h2d, 8'h0f, 8'h33}, ack);
    apply(1'b1);
    chk("cv1", {3'h0, 8'h6d, 1'b0}, cv(second_config_field));
    chk("mp2", {3'h1, 3'h7, 3'h3, 3'h6}, mp(third_config_field));
    chk("buscfg", 12'h1, bus_cfg);
    $display("test apply done");
    u_hcrb_i2c_host.wr(`HCRB_I2C_ADDR, `HCRB_OFS_S1A, 4,
                       '{8'h08, 8'h01, 8'h0e, 8'h3f}, ack);
    chk("hold", {3'h0, 8'h6d, 1'b0}, cv(second_config_field));
    apply(1'b1);
    chk("low", {3'h0, 8'h0c, 1'b1}, cv(second_config_field));
    chk("top", {3'h0, 8'hc6, 1'b0}, cv(third_config_field));
    $display("test reapply done");
    strap1 <= '{reg_a: 8'h03, reg_b: 8'h12};
    apply(1'b0);
    chk("strap", {3'h1, 3'h1, 3'h2, 3'h2}, mp(second_config_field));
    chk("buscfg", 12'h0, bus_cfg);
    $display("test strap done");
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
